// >>> pmrc_far_model.sv
// far side model: core sleep requests, wake sources and pins
`timescale 1ns/1ns
module pmrc_far_model (
  // clock
  input logic                  hclk,
  // core and peripherals
  output logic                 core_sleep_req,
  output pmrc_pkg::pmrc_wake_t wake_src,
  // pins
  output logic                 reset_pin,
  output logic                 wake_pin
);
  initial
  begin
    core_sleep_req = 1'b0;
    wake_src = '0;
    reset_pin = 1'b1;
    wake_pin = 1'b1;
  end
  task automatic sleep_req();
    @(posedge hclk) core_sleep_req <= 1'b1;
    @(posedge hclk) core_sleep_req <= 1'b0;
  endtask
  // two cycles low, the shortest pulse the pin filter passes
  task automatic pin_pulse();
    @(posedge hclk) reset_pin <= 1'b0;
    @(posedge hclk);
    @(posedge hclk) reset_pin <= 1'b1;
  endtask
  // reset held low through scan
  task automatic scan(input logic on);
    @(posedge hclk) reset_pin <= !on;
  endtask
  task automatic wake();
    @(posedge hclk) wake_pin <= 1'b0;
    repeat (4) @(posedge hclk);
    wake_pin <= 1'b1;
  endtask
  task automatic irq(input pmrc_pkg::pmrc_wake_t v);
    @(posedge hclk) wake_src <= v;
    repeat (4) @(posedge hclk);
    wake_src <= '0;
  endtask
endmodule

// >>> pmrc_params.svh
// constants for the power mode and reset controller
`ifndef PMRC_PARAMS_SVH
`define PMRC_PARAMS_SVH
`define PMRC_CLK_HZ          20000000
`define PMRC_RST_PULSE_NS    50
// least time rounds up, at least one cycle
`define PMRC_RST_PULSE_CYC   (((`PMRC_RST_PULSE_NS * (`PMRC_CLK_HZ / 1000000)) + 999) / 1000)
`define PMRC_RST_STRETCH_CYC 16
`define PMRC_ADDR_MODE       12'h000
`define PMRC_ADDR_LOCK       12'h004
`define PMRC_ADDR_STATUS     12'h008
`define PMRC_ADDR_CLKGATE    12'h00C
`define PMRC_ADDR_WAKESEL    12'h010
`define PMRC_ADDR_SUPPLY     12'h014
`define PMRC_ADDR_SLEEPREQ   12'h018
`define PMRC_CLKGATE_RST     32'h0000_0000
`define PMRC_WAKESEL_RST     8'h00
`define PMRC_SUPPLY_RST      8'h00
`define PMRC_BOOT_VECTOR     32'h0000_0000
`endif

// >>> pmrc_pkg.sv
// types for the power mode and reset controller
package pmrc_pkg;
  typedef enum logic [2:0] {
    PMRC_ACTIVE,
    PMRC_SLEEP,
    PMRC_DEEP_SLEEP,
    PMRC_POWER_DOWN,
    PMRC_DEEP_PD
  } pmrc_mode_t;

  // wake sources from peripherals
  typedef struct packed {
    logic [7:0] gpio;
    logic       wdt_irq;
    logic       rtc_irq;
    logic [3:0] uart_irq;
    logic [3:0] uart_lp_cfg;
    logic       any_irq;
  } pmrc_wake_t;

  // power and clock gating outputs
  typedef struct packed {
    logic        core_clk_en;
    logic        periph_clk_en;
    logic        irc_out_en;
    logic        wdt_osc_en;
    logic        sysosc_en;
    logic        analog_en;
    logic        flash_standby;
    logic        flash_off;
    logic        supply_mon_en;
    logic        main_power_en;
  } pmrc_power_t;

  typedef struct packed {
    pmrc_mode_t  mode;
    pmrc_mode_t  sel_mode;
    logic        dpd_lock;
    logic        wdt_sel_irc;
    logic        keep_wdt_osc;
    logic        keep_mon;
    logic [31:0] clkgate;
    logic [7:0]  wakesel;
    logic [1:0]  mon_irq_lvl;
    logic [1:0]  mon_rst_lvl;
    logic        mon_rst_en;
    logic [2:0]  pin_sync;
    logic [2:0]  wake_sync;
    logic        pin_lvl;
    logic        wake_lvl;
    logic [3:0]  pulse_cnt;
    logic [4:0]  stretch;
    logic        rst_active;
    logic [3:0]  rst_cause;
    logic        mon_irq;
    pmrc_power_t pwr;
    logic        hready;
    logic [31:0] hrdata;
    logic        dph_valid;
    logic        dph_write;
    logic [11:0] dph_addr;
    logic        jtag_sel;
    logic        swd_en;
  } pmrc_state_t;
endpackage

// >>> pmrc_top.sv
// power mode and reset controller with ahb-lite register slave
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
`include "pmrc_params.svh"

// Operation
// R1: entering sleep stops core clock; wake restarts it.
// R2: sleep halts execution until reset or interrupt; peripherals keep running.
// R3: deep-sleep stops peripheral clocks and sources; irc out only for watchdog.
// R4: deep-sleep shuts analog, flash standby; watchdog osc and monitor optional.
// R5: deep-sleep wakes on reset, gpio, watchdog, rtc, serial ports one-four.
// R6: serial wake only if port in 32 kHz, synchronous or cts mode.
// R7: power-down keeps only selected watchdog osc; analog, flash off; monitor optional.
// R8: power-down wakes on reset, gpio, watchdog, rtc, serial ports.
// R9: deep power-down powers off all; wakes only on wake pin or rtc.
// R10: lock bit refuses deep power-down entry.
// R11: outside holds wake pin high, pulls low to wake; reset pin high.
// R12: reset from pin, watchdog, power-on, monitor restarts irc and flash.
// R13: after reset registers at defaults, core fetches from address zero; pin, watchdog, power-on and monitor resets keep MODE bits 4-6 and SUPPLY.
// R14: reset status output follows the internal reset state.
// R15: reset pin low pulse of 50 ns resets and wakes the part; the code needs the pin low for two cycles, 100 ns.
// R16: reset pin ignored in deep power-down.
// R17: supply monitor raises readable interrupt; selected levels may force reset.
// R18: software control stops each peripheral clock individually.
// R19: reset pin low selects boundary scan, high serial-wire debug; off in reset.
// R20: outside powers up reset high, waits 250 us, scans, then releases.
// R21: low-power mode entered only on core sleep request, otherwise active.
module pmrc_top
(
  // clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // ahb-lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic [31:0]              hrdata,
  output logic                     hresp,
  // core and peripherals
  input  wire logic                core_sleep_req,
  input  wire logic                wdt_reset,
  input  wire logic                por_reset,
  input  wire pmrc_pkg::pmrc_wake_t wake_src,
  input  wire logic [1:0]          supply_level,
  // pins
  input  wire logic                reset_pin,
  input  wire logic                reset_fn_sel,
  input  wire logic                wake_pin,
  // outputs
  output pmrc_pkg::pmrc_power_t    power_ctl,
  output logic [31:0]              periph_clk_gate,
  output logic                     reset_status_output,
  output logic                     core_reset,
  output logic [31:0]              boot_vector,
  output logic                     supply_mon_irq,
  output logic                     jtag_select,
  output logic                     swd_enable,
  output logic [2:0]               mode_out
);

  pmrc_pkg::pmrc_state_t st_ff;
  pmrc_pkg::pmrc_state_t nxt_st;

  function automatic pmrc_pkg::pmrc_power_t power_for(
    input pmrc_pkg::pmrc_mode_t m,
    input logic wdt_irc,
    input logic keep_osc,
    input logic keep_mon);
    pmrc_pkg::pmrc_power_t p;
    p = '{core_clk_en:1'b1, periph_clk_en:1'b1, irc_out_en:1'b1, wdt_osc_en:1'b1,
          sysosc_en:1'b1, analog_en:1'b1, flash_standby:1'b0, flash_off:1'b0,
          supply_mon_en:1'b1, main_power_en:1'b1};
    case (m)
      pmrc_pkg::PMRC_ACTIVE:
        p = p;
      pmrc_pkg::PMRC_SLEEP:
        p.core_clk_en = 1'b0; // see R1 see R2
      pmrc_pkg::PMRC_DEEP_SLEEP:
      begin
        p.core_clk_en   = 1'b0;
        p.periph_clk_en = 1'b0; // see R3
        p.sysosc_en     = 1'b0;
        p.irc_out_en    = wdt_irc;
        p.wdt_osc_en    = keep_osc; // see R4
        p.analog_en     = 1'b0;
        p.flash_standby = 1'b1;
        p.supply_mon_en = keep_mon;
      end
      pmrc_pkg::PMRC_POWER_DOWN:
      begin
        p.core_clk_en   = 1'b0;
        p.periph_clk_en = 1'b0; // see R7
        p.sysosc_en     = 1'b0;
        p.irc_out_en    = 1'b0;
        p.wdt_osc_en    = keep_osc;
        p.analog_en     = 1'b0;
        p.flash_off     = 1'b1;
        p.supply_mon_en = keep_mon;
      end
      pmrc_pkg::PMRC_DEEP_PD:
      begin
        p = '0; // see R9
      end
      default:
        p = p;
    endcase
    return p;
  endfunction

  logic       pin_low;
  logic       low_wake;
  logic       uart_wake;
  logic       mon_below_irq;
  logic       mon_below_rst;
  logic       reset_req;

  always_comb
  begin
    nxt_st = st_ff;
    // reset pin and wake pin through three flops, change when last two agree
    nxt_st.pin_sync  = {st_ff.pin_sync[1:0], reset_pin};
    nxt_st.wake_sync = {st_ff.wake_sync[1:0], wake_pin};
    if (st_ff.pin_sync[1] == st_ff.pin_sync[2])
      nxt_st.pin_lvl = st_ff.pin_sync[2];
    if (st_ff.wake_sync[1] == st_ff.wake_sync[2])
      nxt_st.wake_lvl = st_ff.wake_sync[2];

    // low pulse qualified for at least the minimum width
    pin_low = !st_ff.pin_lvl && reset_fn_sel && (st_ff.mode != pmrc_pkg::PMRC_DEEP_PD); // see R16
    if (pin_low && st_ff.pulse_cnt < 4'(`PMRC_RST_PULSE_CYC))
      nxt_st.pulse_cnt = st_ff.pulse_cnt + 4'h1;
    else if (!pin_low)
      nxt_st.pulse_cnt = 4'h0;

    mon_below_irq = (supply_level <= st_ff.mon_irq_lvl) && st_ff.pwr.supply_mon_en;
    mon_below_rst = st_ff.mon_rst_en && (supply_level <= st_ff.mon_rst_lvl)
                    && st_ff.pwr.supply_mon_en; // see R17
    nxt_st.mon_irq = mon_below_irq; // see R17

    reset_req = wdt_reset || por_reset || mon_below_rst
                || (pin_low && st_ff.pulse_cnt >= 4'(`PMRC_RST_PULSE_CYC)); // see R12 see R15

    // wake decision per mode
    uart_wake = |(wake_src.uart_irq & wake_src.uart_lp_cfg); // see R6
    low_wake  = (|(wake_src.gpio & st_ff.wakesel)) || wake_src.wdt_irq
                || wake_src.rtc_irq || uart_wake; // see R5 see R8

    case (st_ff.mode)
      pmrc_pkg::PMRC_ACTIVE:
        if (core_sleep_req) // see R21
        begin
          if (st_ff.sel_mode == pmrc_pkg::PMRC_DEEP_PD && st_ff.dpd_lock)
            nxt_st.mode = pmrc_pkg::PMRC_POWER_DOWN; // see R10
          else
            nxt_st.mode = st_ff.sel_mode;
        end
      pmrc_pkg::PMRC_SLEEP:
        if (wake_src.any_irq)
          nxt_st.mode = pmrc_pkg::PMRC_ACTIVE; // see R2
      pmrc_pkg::PMRC_DEEP_SLEEP,
      pmrc_pkg::PMRC_POWER_DOWN:
        if (low_wake)
          nxt_st.mode = pmrc_pkg::PMRC_ACTIVE;
      pmrc_pkg::PMRC_DEEP_PD:
        if (!st_ff.wake_lvl || wake_src.rtc_irq)
        begin
          nxt_st.mode    = pmrc_pkg::PMRC_ACTIVE; // see R9
          nxt_st.stretch = 5'(`PMRC_RST_STRETCH_CYC);
        end
      default:
        nxt_st.mode = pmrc_pkg::PMRC_ACTIVE;
    endcase

    if (reset_req && st_ff.mode != pmrc_pkg::PMRC_DEEP_PD)
    begin
      // any reset outside deep power-down wakes and restores mode select, lock, clock gate and wake select defaults
      nxt_st.mode        = pmrc_pkg::PMRC_ACTIVE; // see R15
      nxt_st.stretch     = 5'(`PMRC_RST_STRETCH_CYC);
      nxt_st.sel_mode    = pmrc_pkg::PMRC_SLEEP;
      nxt_st.dpd_lock    = 1'b0;
      nxt_st.clkgate     = `PMRC_CLKGATE_RST; // see R13
      nxt_st.wakesel     = `PMRC_WAKESEL_RST;
      nxt_st.rst_cause   = st_ff.rst_cause | {mon_below_rst, por_reset, wdt_reset, pin_low};
    end
    else if (st_ff.stretch != 5'h00)
      nxt_st.stretch = st_ff.stretch - 5'h01;
    nxt_st.rst_active = (nxt_st.stretch != 5'h00); // see R14

    nxt_st.pwr = power_for(nxt_st.mode, st_ff.wdt_sel_irc, st_ff.keep_wdt_osc,
                           st_ff.keep_mon);
    if (nxt_st.rst_active)
      nxt_st.pwr.core_clk_en = 1'b0; // see R12

    nxt_st.jtag_sel = !st_ff.pin_lvl; // see R19
    nxt_st.swd_en   = st_ff.pin_lvl && !st_ff.rst_active; // see R19

    // ahb-lite data phase, zero wait states
    nxt_st.hready = 1'b1;
    if (st_ff.dph_valid && st_ff.dph_write)
    begin
      case (st_ff.dph_addr)
        `PMRC_ADDR_MODE:
        begin
          nxt_st.sel_mode     = pmrc_pkg::pmrc_mode_t'(hwdata[2:0]);
          nxt_st.wdt_sel_irc  = hwdata[4];
          nxt_st.keep_wdt_osc = hwdata[5];
          nxt_st.keep_mon     = hwdata[6];
        end
        `PMRC_ADDR_LOCK:
          nxt_st.dpd_lock = hwdata[0];
        `PMRC_ADDR_STATUS:
          nxt_st.rst_cause = st_ff.rst_cause & ~hwdata[3:0];
        `PMRC_ADDR_CLKGATE:
          nxt_st.clkgate = hwdata; // see R18
        `PMRC_ADDR_WAKESEL:
          nxt_st.wakesel = hwdata[7:0];
        `PMRC_ADDR_SUPPLY:
        begin
          nxt_st.mon_irq_lvl = hwdata[1:0];
          nxt_st.mon_rst_lvl = hwdata[5:4];
          nxt_st.mon_rst_en  = hwdata[7];
        end
        // unmapped: write dropped
        default:
          ;
      endcase
      // set wins over clear for hardware-set cause bits
      if (reset_req)
        nxt_st.rst_cause = nxt_st.rst_cause | {mon_below_rst, por_reset, wdt_reset, pin_low};
    end
    nxt_st.dph_valid = hsel && hready && htrans[1];
    nxt_st.dph_write = hwrite;
    nxt_st.dph_addr  = haddr[11:0];
    if (hsel && hready && htrans[1] && !hwrite)
    begin
      case (haddr[11:0])
        `PMRC_ADDR_MODE:
          nxt_st.hrdata = {25'h0, st_ff.keep_mon, st_ff.keep_wdt_osc, st_ff.wdt_sel_irc,
                           1'b0, st_ff.sel_mode};
        `PMRC_ADDR_LOCK:
          nxt_st.hrdata = {31'h0, st_ff.dpd_lock};
        `PMRC_ADDR_STATUS:
          nxt_st.hrdata = {24'h0, 1'b0, st_ff.mode, st_ff.mon_irq, 2'b00,
                           st_ff.rst_active} | {28'h0, st_ff.rst_cause} << 8;
        `PMRC_ADDR_CLKGATE:
          nxt_st.hrdata = st_ff.clkgate;
        `PMRC_ADDR_WAKESEL:
          nxt_st.hrdata = {24'h0, st_ff.wakesel};
        `PMRC_ADDR_SUPPLY:
          nxt_st.hrdata = {24'h0, st_ff.mon_rst_en, 1'b0, st_ff.mon_rst_lvl,
                           2'b00, st_ff.mon_irq_lvl};
        default:
          nxt_st.hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff              <= '0;
      st_ff.mode         <= pmrc_pkg::PMRC_ACTIVE;
      st_ff.sel_mode     <= pmrc_pkg::PMRC_SLEEP;
      st_ff.clkgate      <= `PMRC_CLKGATE_RST;
      st_ff.pin_sync     <= 3'h7;
      st_ff.wake_sync    <= 3'h7;
      st_ff.pin_lvl      <= 1'b1;
      st_ff.wake_lvl     <= 1'b1;
      st_ff.stretch      <= 5'(`PMRC_RST_STRETCH_CYC);
      st_ff.rst_active   <= 1'b1;
      st_ff.hready       <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  // outputs straight from state flops, except hresp and boot_vector, which are constants
  assign hreadyout           = st_ff.hready;
  assign hrdata              = st_ff.hrdata;
  assign hresp               = 1'b0;
  assign power_ctl           = st_ff.pwr;
  assign periph_clk_gate     = st_ff.clkgate;
  assign reset_status_output = st_ff.rst_active;
  assign core_reset          = st_ff.rst_active;
  assign boot_vector         = `PMRC_BOOT_VECTOR; // see R13
  assign supply_mon_irq      = st_ff.mon_irq;
  assign jtag_select         = st_ff.jtag_sel;
  assign swd_enable          = st_ff.swd_en;
  assign mode_out            = st_ff.mode;
endmodule

// >>> pmrc_top_asserts.sv
// assertion checker bound to the power mode and reset controller
`timescale 1ns/1ns
module pmrc_chk (
  // clock and reset
  input logic                  hclk,
  input logic                  hresetn,
  // pins and wake sources
  input logic                  reset_pin,
  input logic                  reset_fn_sel,
  input logic                  wake_pin,
  input pmrc_pkg::pmrc_wake_t  wake_src,
  // controller outputs
  input pmrc_pkg::pmrc_power_t power_ctl,
  input logic                  reset_status_output,
  input logic                  core_reset,
  input logic [31:0]           boot_vector,
  input logic                  jtag_select,
  input logic                  swd_enable,
  input logic [2:0]            mode_out
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_rst_out; reset_status_output == core_reset; endproperty
  a_rst_out: assert property (p_rst_out) else $error("status output differs");
  property p_boot; boot_vector == 32'h0; endproperty
  a_boot: assert property (p_boot) else $error("boot vector not zero");
  property p_sleep;
    (mode_out == 3'h1)[*2] |-> !power_ctl.core_clk_en && power_ctl.periph_clk_en;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep clocks wrong");
  property p_dsleep;
    (mode_out == 3'h2)[*2] |-> !power_ctl.analog_en && power_ctl.flash_standby;
  endproperty
  a_dsleep: assert property (p_dsleep) else $error("deep sleep gating wrong");
  property p_pdown;
    (mode_out == 3'h3)[*2] |-> !power_ctl.analog_en && power_ctl.flash_off;
  endproperty
  a_pdown: assert property (p_pdown) else $error("power down gating wrong");
  property p_dpd; (mode_out == 3'h4)[*2] |-> !power_ctl.main_power_en; endproperty
  a_dpd: assert property (p_dpd) else $error("main power on in deep pd");
  property p_stretch; $rose(hresetn) |-> core_reset[*8]; endproperty
  a_stretch: assert property (p_stretch) else $error("reset stretch short");
  property p_pin;
    $fell(reset_pin) && reset_fn_sel && mode_out != 3'h4 |-> ##[1:6] core_reset;
  endproperty
  a_pin: assert property (p_pin) else $error("pin pulse missed");
  property p_dpd_pin;
    (mode_out == 3'h4 && wake_pin && !wake_src.rtc_irq)[*4] |=> !$rose(core_reset);
  endproperty
  a_dpd_pin: assert property (p_dpd_pin) else $error("reset in deep pd");
  property p_swd; core_reset[*2] |-> !swd_enable; endproperty
  a_swd: assert property (p_swd) else $error("debug on in reset");
  property p_jtag; (!reset_pin && mode_out != 3'h4)[*6] |-> jtag_select; endproperty
  a_jtag: assert property (p_jtag) else $error("scan not selected");
  c_dpd: cover property (mode_out == 3'h4);
  c_sleep: cover property ($rose(mode_out == 3'h1));
  c_pin: cover property ($fell(reset_pin) ##[1:6] core_reset);
endmodule

bind pmrc_top pmrc_chk u_chk (
  .hclk(hclk), .hresetn(hresetn), .reset_pin(reset_pin), .reset_fn_sel(reset_fn_sel),
  .wake_pin(wake_pin), .wake_src(wake_src), .power_ctl(power_ctl),
  .reset_status_output(reset_status_output), .core_reset(core_reset),
  .boot_vector(boot_vector), .jtag_select(jtag_select), .swd_enable(swd_enable),
  .mode_out(mode_out)
);

// >>> power_mode_and_reset_control_test.sv
// self-checking testbench for the power mode and reset controller
`timescale 1ns/1ns
`include "pmrc_params.svh"
module power_mode_and_reset_control_test;
  logic                  hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]           haddr, hwdata, hrdata, periph_clk_gate, boot_vector, q;
  logic [1:0]            htrans, supply_level;
  logic [2:0]            hsize, mode_out;
  logic                  core_sleep_req, wdt_reset, por_reset, reset_pin, reset_fn_sel;
  logic                  wake_pin, reset_status_output, core_reset, supply_mon_irq;
  logic                  jtag_select, swd_enable;
  pmrc_pkg::pmrc_wake_t  wake_src;
  pmrc_pkg::pmrc_power_t power_ctl;
  int                    fail_count, tests_run;
  logic [18:0]           wv [4] = '{19'h00800, 19'h00400, 19'h00200, 19'h00022};

  assign hready = hreadyout;
  always #25 hclk = ~hclk;

  pmrc_top u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .core_sleep_req(core_sleep_req), .wdt_reset(wdt_reset), .por_reset(por_reset),
    .wake_src(wake_src), .supply_level(supply_level), .reset_pin(reset_pin),
    .reset_fn_sel(reset_fn_sel), .wake_pin(wake_pin), .power_ctl(power_ctl),
    .periph_clk_gate(periph_clk_gate), .reset_status_output(reset_status_output),
    .core_reset(core_reset), .boot_vector(boot_vector), .supply_mon_irq(supply_mon_irq),
    .jtag_select(jtag_select), .swd_enable(swd_enable), .mode_out(mode_out)
  );
  pmrc_far_model u_far (
    .hclk(hclk), .core_sleep_req(core_sleep_req), .wake_src(wake_src),
    .reset_pin(reset_pin), .wake_pin(wake_pin)
  );

  task automatic tally_and_finish();
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wait_ready();
    for (int n = 0; n < 50; n++)
    begin
      @(posedge hclk);
      if (hreadyout === 1'b1)
        return;
    end
    fail_count++;
    tally_and_finish();
  endtask
  // mode (r low) or internal reset (r high), then two edges to settle
  task automatic wait_on(input bit r, input logic [2:0] v);
    for (int n = 0; n < 80; n++)
    begin
      if ((r ? {2'b00, core_reset} : mode_out) === v)
      begin
        tests_run++;
        repeat (2) @(posedge hclk);
        return;
      end
      @(posedge hclk);
    end
    $display("MISMATCH wait expected %h seen %h", v, mode_out);
    fail_count++;
    tally_and_finish();
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0, a};
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("reg", q, e);
  endtask

  initial
  begin
    hclk = 0;
    hresetn = 0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    htrans = 2'h0;
    wdt_reset = 1'b0;
    por_reset = 1'b0;
    hsize = 3'h2;
    supply_level = 2'h3;
    reset_fn_sel = 1'b1;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("rst_out", reset_status_output, 1'b1);
    wait_on(1, 3'h0);
    chk("boot", boot_vector, `PMRC_BOOT_VECTOR);
    chk("swd", swd_enable, 1'b1);
    rd(`PMRC_ADDR_MODE, 32'h1);
    rd(`PMRC_ADDR_LOCK, 32'h0);
    rd(`PMRC_ADDR_WAKESEL, 32'h0);
    rd(`PMRC_ADDR_SUPPLY, 32'h0);
    bus(1'b1, 12'h040, 32'hFFFF_FFFF);
    rd(12'h040, 32'h0);
    bus(1'b1, `PMRC_ADDR_CLKGATE, 32'hA5A5_0F0F);
    @(posedge hclk);
    chk("gate", periph_clk_gate, 32'hA5A5_0F0F);
    bus(1'b1, `PMRC_ADDR_MODE, 32'h1);
    repeat (4) @(posedge hclk);
    chk("mode", mode_out, 3'h0);
    u_far.sleep_req();
    wait_on(0, 3'h1);
    chk("core_clk", power_ctl.core_clk_en, 1'b0);
    chk("per_clk", power_ctl.periph_clk_en, 1'b1);
    u_far.irq(19'h00001);
    wait_on(0, 3'h0);
    chk("core_clk", power_ctl.core_clk_en, 1'b1);
    bus(1'b1, `PMRC_ADDR_MODE, 32'h12);
    u_far.sleep_req();
    wait_on(0, 3'h2);
    chk("irc_out", power_ctl.irc_out_en, 1'b1);
    chk("per_clk", power_ctl.periph_clk_en, 1'b0);
    chk("fl_stby", power_ctl.flash_standby, 1'b1);
    u_far.irq(19'h00020);
    repeat (6) @(posedge hclk);
    chk("mode", mode_out, 3'h2);
    u_far.irq(19'h00022);
    wait_on(0, 3'h0);
    bus(1'b1, `PMRC_ADDR_MODE, 32'h3);
    bus(1'b1, `PMRC_ADDR_WAKESEL, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      u_far.sleep_req();
      wait_on(0, 3'h3);
      chk("wdt_osc", power_ctl.wdt_osc_en, 1'b0);
      u_far.irq(wv[i]);
      wait_on(0, 3'h0);
    end
    u_far.sleep_req();
    wait_on(0, 3'h3);
    u_far.pin_pulse();
    wait_on(1, 3'h1);
    wait_on(0, 3'h0);
    wait_on(1, 3'h0);
    rd(`PMRC_ADDR_CLKGATE, `PMRC_CLKGATE_RST);
    bus(1'b1, `PMRC_ADDR_LOCK, 32'h1);
    bus(1'b1, `PMRC_ADDR_MODE, 32'h4);
    u_far.sleep_req();
    wait_on(0, 3'h3);
    u_far.irq(19'h00200);
    wait_on(0, 3'h0);
    bus(1'b1, `PMRC_ADDR_LOCK, 32'h0);
    u_far.sleep_req();
    wait_on(0, 3'h4);
    chk("power", power_ctl.main_power_en, 1'b0);
    u_far.pin_pulse();
    u_far.irq(19'h00001);
    chk("mode", mode_out, 3'h4);
    chk("reset", core_reset, 1'b0);
    u_far.wake();
    wait_on(0, 3'h0);
    wait_on(1, 3'h0);
    bus(1'b1, `PMRC_ADDR_SUPPLY, 32'h2);
    supply_level <= 2'h1;
    repeat (6) @(posedge hclk);
    chk("mon_irq", supply_mon_irq, 1'b1);
    bus(1'b0, `PMRC_ADDR_STATUS, 32'h0);
    chk("mon_sts", q[3], 1'b1);
    bus(1'b1, `PMRC_ADDR_SUPPLY, 32'h90);
    wait_on(1, 3'h1);
    supply_level <= 2'h3;
    wait_on(1, 3'h0);
    for (int i = 0; i < 2; i++)
    begin
      {por_reset, wdt_reset} <= 2'b01 << i;
      wait_on(1, 3'h1);
      {por_reset, wdt_reset} <= 2'b00;
      wait_on(1, 3'h0);
      bus(1'b0, `PMRC_ADDR_STATUS, 32'h0);
      chk("cause", q[9 + i], 1'b1);
    end
    reset_fn_sel <= 1'b0;
    u_far.pin_pulse();
    repeat (6) @(posedge hclk);
    chk("pin_off", core_reset, 1'b0);
    reset_fn_sel <= 1'b1;
    u_far.scan(1'b1);
    repeat (6) @(posedge hclk);
    chk("jtag", jtag_select, 1'b1);
    chk("swd", swd_enable, 1'b0);
    u_far.scan(1'b0);
    wait_on(1, 3'h0);
    chk("jtag", jtag_select, 1'b0);
    tally_and_finish();
  end
endmodule
